// *** rtl/tmrb_pkg.sv ***
// constants for the two-channel temperature monitor register bank
// assumes a byte-level serial bus front end and an external converter
package tmrb_pkg;
  ////////////////////////////////////////////////////////////////////
  // read addresses
  localparam logic [7:0] RD_LOCAL_VALUE  = 8'h00;
  localparam logic [7:0] RD_REMOTE_VALUE = 8'h01;
  localparam logic [7:0] RD_ALARM_FLAGS  = 8'h02;
  localparam logic [7:0] RD_CONTROL      = 8'h03;
  localparam logic [7:0] RD_RATE         = 8'h04;
  localparam logic [7:0] RD_LOCAL_UPPER  = 8'h05;
  localparam logic [7:0] RD_LOCAL_LOWER  = 8'h06;
  localparam logic [7:0] RD_REMOTE_UPPER = 8'h07;
  localparam logic [7:0] RD_REMOTE_LOWER = 8'h08;
  localparam logic [7:0] RD_MAKER_ID     = 8'hfe;
  localparam logic [7:0] RD_REVISION     = 8'hff;
  // write addresses
  localparam logic [7:0] WR_CONTROL      = 8'h09;
  localparam logic [7:0] WR_RATE         = 8'h0a;
  localparam logic [7:0] WR_LOCAL_UPPER  = 8'h0b;
  localparam logic [7:0] WR_LOCAL_LOWER  = 8'h0c;
  localparam logic [7:0] WR_REMOTE_UPPER = 8'h0d;
  localparam logic [7:0] WR_REMOTE_LOWER = 8'h0e;
  localparam logic [7:0] WR_ONE_SHOT     = 8'h0f;
  ////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] RST_POINTER     = 8'h00;
  localparam logic [7:0] RST_VALUE       = 8'h00;
  localparam logic [7:0] RST_CONTROL     = 8'h00;
  localparam logic [7:0] RST_RATE        = 8'h02;
  localparam logic [7:0] RST_UPPER       = 8'h7f;
  localparam logic [7:0] RST_LOWER       = 8'hc9;
  // field positions
  localparam int FLAG_BUSY_BIT   = 7;
  localparam int FLAG_LSB_BIT    = 2;
  localparam int CTRL_MASK_BIT   = 7;
  localparam int CTRL_STANDBY_PIN_N_BIT   = 6;
  localparam int RATE_CODE_WIDTH = 3;
  localparam logic [2:0] RATE_FASTEST = 3'h7;
  ////////////////////////////////////////////////////////////////////
  // timing: fastest conversion period, code 7
  localparam int CLK_FREQ_HZ     = 100_000_000;
  localparam int FAST_PERIOD_US  = 125_000;
  localparam int FAST_PERIOD_CYC = FAST_PERIOD_US * (CLK_FREQ_HZ / 1_000_000);
endpackage : tmrb_pkg

// *** rtl/tmrb_limit_cmp.sv ***
// one channel's limit comparator
// assumes limits and value are two's complement bytes held in flops
`timescale 1ns/1ps
module tmrb_limit_cmp
  import tmrb_pkg::*;
#(
  parameter int WIDTH = 8
)(
  input  wire logic [WIDTH-1:0] value,
  input  wire logic [WIDTH-1:0] upper,
  input  wire logic [WIDTH-1:0] lower,
  output logic                  over,
  output logic                  under
);
  // signed compare; equal to a limit never trips
  assign over  = $signed(value) > $signed(upper);
  assign under = $signed(value) < $signed(lower);
endmodule : tmrb_limit_cmp

// *** rtl/tmrb_register_bank.sv ***
// register bank, conversion timing and alarm latch of the monitor
// assumes a byte-level bus front end and a converter that reports done
`timescale 1ns/1ps
module tmrb_register_bank
  import tmrb_pkg::*;
#(
  parameter int unsigned    CONV_BASE_CYCLES = FAST_PERIOD_CYC,
  parameter logic [7:0]     MAKER_ID         = 8'h5a, // arbitrary value
  parameter logic [7:0]     REVISION         = 8'h01  // arbitrary value
)(
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       bus_start,
  input  wire logic       bus_read,
  input  wire logic       bus_byte_valid,
  input  wire logic [7:0] bus_byte,
  input  wire logic       bus_rd_req,
  input  wire logic       alert_resp,
  input  wire logic       standby_pin_n,
  input  wire logic       adc_done,
  input  wire logic [7:0] adc_local,
  input  wire logic [7:0] adc_remote,
  input  wire logic       adc_open,
  output logic [7:0]      rd_data,
  output logic            rd_valid,
  output logic            conv_start,
  output logic            alert_o,
  output logic            alert_oe
);
  ////////////////////////////////////////////////////////////////////
  // state
  logic [7:0]  pointer;
  logic        wr_first;
  logic [7:0]  local_temp_value;
  logic [7:0]  remote_temp_value;
  logic [7:0]  device_control;
  logic [7:0]  sample_rate_select;
  logic [7:0]  local_upper_bound;
  logic [7:0]  local_lower_bound;
  logic [7:0]  remote_upper_bound;
  logic [7:0]  remote_lower_bound;
  logic [4:0]  flags;
  logic        open_state;
  logic        busy;
  logic        alarm_latch;
  logic [31:0] timer;
  logic [31:0] period_last;
  logic        standby;
  logic        data_wr;
  logic        ptr_wr;
  logic        one_shot_wr;
  logic        status_rd;
  logic        timer_due;
  logic [4:0]  cond;
  logic        local_over_limit;
  logic        local_under_limit;
  logic        remote_over_limit;
  logic        remote_under_limit;
  logic [7:0]  next_rd_data;

  ////////////////////////////////////////////////////////////////////
  // write transaction decode: first byte is the pointer
  assign ptr_wr      = bus_byte_valid && wr_first;
  assign data_wr     = bus_byte_valid && !wr_first && !bus_read;
  assign one_shot_wr = data_wr && pointer == WR_ONE_SHOT;
  assign status_rd   = bus_rd_req && pointer == RD_ALARM_FLAGS;

  // byte order tracker within one write
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      wr_first <= 1'b0;
    else if (bus_start)
      wr_first <= !bus_read;
    else if (bus_byte_valid)
      wr_first <= 1'b0;
  end

  // pointer; no address of its own
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      pointer <= RST_POINTER;
    else if (ptr_wr)
      pointer <= bus_byte;
  end

  ////////////////////////////////////////////////////////////////////
  // writable registers; writes to read addresses or above 0f do nothing
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      device_control     <= RST_CONTROL;
      sample_rate_select <= RST_RATE;
      local_upper_bound  <= RST_UPPER;
      local_lower_bound  <= RST_LOWER;
      remote_upper_bound <= RST_UPPER;
      remote_lower_bound <= RST_LOWER;
    end
    else if (data_wr)
    begin
      unique case (pointer)
        WR_CONTROL:      device_control     <= bus_byte & 8'hc0;
        WR_RATE:         sample_rate_select <= bus_byte;
        WR_LOCAL_UPPER:  local_upper_bound  <= bus_byte;
        WR_LOCAL_LOWER:  local_lower_bound  <= bus_byte;
        WR_REMOTE_UPPER: remote_upper_bound <= bus_byte;
        WR_REMOTE_LOWER: remote_lower_bound <= bus_byte;
        default:         device_control     <= device_control;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // value registers; the bus has no path into them
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      local_temp_value  <= RST_VALUE;
      remote_temp_value <= RST_VALUE;
      open_state        <= 1'b0;
    end
    else if (adc_done)
    begin
      local_temp_value  <= adc_local;
      remote_temp_value <= adc_remote;
      open_state        <= adc_open;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // conversion timing
  assign standby   = device_control[CTRL_STANDBY_PIN_N_BIT] || !standby_pin_n;
  // slowest code is 128 base periods, still inside 32 bits
  assign period_last = (CONV_BASE_CYCLES << (RATE_FASTEST -
                        sample_rate_select[RATE_CODE_WIDTH-1:0])) - 32'd1;
  assign timer_due = !standby && timer >= period_last;

  // free-running period counter, cleared and held at zero in standby
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      timer <= 32'd0;
    else if (standby || timer_due)
      timer <= 32'd0;
    else
      timer <= timer + 32'd1;
  end

  // start pulse: period tick or one-shot; never while busy
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      conv_start <= 1'b0;
    else
      conv_start <= !busy && !conv_start && (timer_due || one_shot_wr);
  end

  // busy from start to the converter's done
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      busy <= 1'b0;
    else if (conv_start)
      busy <= 1'b1;
    else if (adc_done)
      busy <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////
  // comparisons on the stored values
  tmrb_limit_cmp #(.WIDTH(8)) u_local_cmp (
    .value (local_temp_value),
    .upper (local_upper_bound),
    .lower (local_lower_bound),
    .over  (local_over_limit),
    .under (local_under_limit)
  );

  tmrb_limit_cmp #(.WIDTH(8)) u_remote_cmp (
    .value (remote_temp_value),
    .upper (remote_upper_bound),
    .lower (remote_lower_bound),
    .over  (remote_over_limit),
    .under (remote_under_limit)
  );

  assign cond = {local_over_limit, local_under_limit,
                 remote_over_limit, remote_under_limit, open_state};

  // sticky flags; a live condition beats the read clear
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      flags <= 5'h00;
    else
      flags <= cond | (flags & ~{5{status_rd}});
  end

  // alarm latch survives status reads, cleared by alert response
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      alarm_latch <= 1'b0;
    else if (|flags)
      alarm_latch <= 1'b1;
    else if (alert_resp && !(|cond))
      alarm_latch <= 1'b0;
  end

  // open drain: only ever pulls low
  assign alert_o  = 1'b0;
  assign alert_oe = alarm_latch && !device_control[CTRL_MASK_BIT];

  ////////////////////////////////////////////////////////////////////
  // read mux; write-only addresses read as zero
  always_comb
  begin
    next_rd_data = 8'h00;
    unique case (pointer)
      RD_LOCAL_VALUE:  next_rd_data = local_temp_value;
      RD_REMOTE_VALUE: next_rd_data = remote_temp_value;
      RD_ALARM_FLAGS:  next_rd_data = {busy, flags, 2'b00};
      RD_CONTROL:      next_rd_data = device_control;
      RD_RATE:         next_rd_data = sample_rate_select;
      RD_LOCAL_UPPER:  next_rd_data = local_upper_bound;
      RD_LOCAL_LOWER:  next_rd_data = local_lower_bound;
      RD_REMOTE_UPPER: next_rd_data = remote_upper_bound;
      RD_REMOTE_LOWER: next_rd_data = remote_lower_bound;
      RD_MAKER_ID:     next_rd_data = MAKER_ID;
      RD_REVISION:     next_rd_data = REVISION;
      default:         next_rd_data = 8'h00;
    endcase
  end

  // read byte captured on request, valid one cycle later
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      rd_data  <= 8'h00;
      rd_valid <= 1'b0;
    end
    else
    begin
      rd_valid <= bus_rd_req;
      if (bus_rd_req)
        rd_data <= next_rd_data;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_ptr_byte;
    ptr_wr;
  endsequence

  sequence s_oneshot_idle;
    one_shot_wr && !busy && !conv_start;
  endsequence

  sequence s_status_read;
    bus_rd_req && pointer == RD_ALARM_FLAGS;
  endsequence

  a_ptr_load: assert property (
    s_ptr_byte |=> pointer == $past(bus_byte))
    else $error("pointer not loaded by first byte");

  a_ptr_reset: assert property (disable iff (1'b0)
    !reset_n |=> pointer == 8'h00)
    else $error("pointer not 00 after reset");

  a_limit_reset: assert property (disable iff (1'b0)
    !reset_n |=> local_upper_bound == 8'h7f && remote_lower_bound == 8'hc9
                 && sample_rate_select == 8'h02 && device_control == 8'h00)
    else $error("wrong power-on register values");

  a_value_ro: assert property (
    !$stable(local_temp_value) |-> $past(adc_done))
    else $error("value register changed without converter");

  a_busy_bit: assert property (
    s_status_read |=> rd_valid && rd_data[7] == $past(busy) && rd_data[1:0] == 2'b00)
    else $error("status busy bit wrong");

  a_flag_set: assert property (
    local_over_limit |=> flags[4])
    else $error("over-limit flag not set");

  a_flag_hold: assert property (
    $fell(flags[0]) |-> $past(status_rd) && !$past(open_state))
    else $error("flag cleared without read or with live cause");

  a_latch_set: assert property (
    (|flags) |=> alarm_latch && alert_oe == !device_control[CTRL_MASK_BIT])
    else $error("alarm not driven for set flag");

  a_latch_keep: assert property (
    $fell(alarm_latch) |-> $past(alert_resp) && $past(flags) == 5'h00)
    else $error("alarm latch cleared wrongly");

  a_alert_mask: assert property (
    device_control[7] |-> !alert_oe)
    else $error("masked alarm still driven");

  a_oneshot_go: assert property (
    s_oneshot_idle |=> conv_start ##1 busy)
    else $error("one-shot did not start conversion");

  a_standby_quiet: assert property (
    conv_start && $past(standby) |-> $past(one_shot_wr))
    else $error("conversion started in standby");

  a_rd_pulse: assert property (
    bus_rd_req |=> rd_valid && rd_data == $past(next_rd_data))
    else $error("read byte not presented one cycle after request");

  a_remote_ro: assert property (
    !$stable(remote_temp_value) |-> $past(adc_done))
    else $error("remote value changed without converter");

  a_flag_clear: assert property (
    status_rd && cond == 5'h00 |=> flags == 5'h00)
    else $error("ended flags not cleared by status read");

  a_open_flag: assert property (
    open_state |=> flags[0])
    else $error("open sensor flag not set");

  a_standby_hold: assert property (
    standby |=> timer == 32'd0)
    else $error("period timer ran in standby");

  a_ctrl_rsvd: assert property (
    device_control[5:0] == 6'h00)
    else $error("reserved control bits not zero");
endmodule : tmrb_register_bank

// *** dv/tmrb_host_model.sv ***
// host side of the byte-level management bus: write and read transfers
// assumes the bank takes requests on the rising edge of clk_sys
`timescale 1ns/1ps
module tmrb_host_model (
  input  wire logic       clk_sys,
  output logic            bus_start,
  output logic            bus_read,
  output logic            bus_byte_valid,
  output logic [7:0]      bus_byte,
  output logic            bus_rd_req,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid
);
  // idle bus, byte lane parked on a pattern
  initial
  begin
    bus_start      = 1'b0;
    bus_read       = 1'b0;
    bus_byte_valid = 1'b0;
    bus_byte       = 8'h5a;
    bus_rd_req     = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////
  // pointer byte, then a data byte if two is set
  // callers send data only to write addresses 09..0f
  task automatic wr(input logic [7:0] ptr, input logic [7:0] dat, input bit two);
    @(posedge clk_sys) #1;
    bus_start = 1'b1;
    bus_read  = 1'b0;
    @(posedge clk_sys) #1;
    bus_start      = 1'b0;
    bus_byte_valid = 1'b1;
    bus_byte       = ptr;
    if (two)
    begin
      @(posedge clk_sys) #1;
      bus_byte = dat;
    end
    @(posedge clk_sys) #1;
    bus_byte_valid = 1'b0;
    // released lane shows the inverse, never a stale byte
    bus_byte = ~bus_byte;
  endtask : wr
  // one read byte; answer sampled one edge after the request
  task automatic rd(output logic [7:0] dat, output logic ok);
    @(posedge clk_sys) #1;
    bus_start = 1'b1;
    bus_read  = 1'b1;
    @(posedge clk_sys) #1;
    bus_start  = 1'b0;
    bus_rd_req = 1'b1;
    @(posedge clk_sys) #1;
    bus_rd_req = 1'b0;
    ok         = rd_valid;
    dat        = rd_data;
    bus_read   = 1'b0;
  endtask : rd
endmodule : tmrb_host_model

// *** dv/test_temp_monitor_register_bank.sv ***
// self-checking bench of the monitor register bank
// assumes the host model above and a converter that answers in 12 cycles
`timescale 1ns/1ps
module test_temp_monitor_register_bank;
  import tmrb_pkg::*;
  logic clk_sys = 1'b0, reset_n = 1'b0, alert_resp = 1'b0, standby_pin_n = 1'b1;
  logic adc_done = 1'b0, adc_open = 1'b0, rd_valid, conv_start, alert_o, alert_oe;
  logic bus_start, bus_read, bus_byte_valid, bus_rd_req;
  logic [7:0] bus_byte, rd_data, adc_local = 8'h00, adc_remote = 8'h00;
  int fails = 0, compares = 0, nstart = 0, ndone = 0, cdown = 0;
  logic [7:0] ra[11] = '{8'h02,8'h00,8'h01,8'h03,8'h04,8'h05,8'h06,8'h07,8'h08,8'hfe,8'hff};
  logic [7:0] re[11] = '{8'h00,8'h00,8'h00,8'h00,8'h02,8'h7f,8'hc9,8'h7f,8'hc9,8'h5a,8'h01};
  always #5 clk_sys = ~clk_sys;
  tmrb_register_bank #(.CONV_BASE_CYCLES(16)) dut (.clk_sys(clk_sys), .reset_n(reset_n),
    .bus_start(bus_start), .bus_read(bus_read), .bus_byte_valid(bus_byte_valid),
    .bus_byte(bus_byte), .bus_rd_req(bus_rd_req), .alert_resp(alert_resp),
    .standby_pin_n(standby_pin_n), .adc_done(adc_done), .adc_local(adc_local),
    .adc_remote(adc_remote), .adc_open(adc_open), .rd_data(rd_data), .rd_valid(rd_valid),
    .conv_start(conv_start), .alert_o(alert_o), .alert_oe(alert_oe));
  tmrb_host_model host (.clk_sys(clk_sys), .bus_start(bus_start), .bus_read(bus_read),
    .bus_byte_valid(bus_byte_valid), .bus_byte(bus_byte), .bus_rd_req(bus_rd_req),
    .rd_data(rd_data), .rd_valid(rd_valid));
  // converter stand-in: answers each start after 12 cycles
  always @(posedge clk_sys)
  begin
    adc_done <= (cdown == 1);
    if (adc_done) ndone++;
    if (conv_start === 1'b1) nstart++;
    if (conv_start === 1'b1) cdown <= 12;
    else if (cdown != 0) cdown <= cdown - 1;
  end
  ////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // set pointer, read one byte; a missing rd_valid forces a mismatch
  task automatic rdp(input logic [7:0] ptr, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    host.wr(ptr, 8'h00, 1'b0);
    host.rd(d, ok);
    check(ok === 1'b1 ? d : ~exp, exp);
  endtask : rdp
  task automatic wait_done(input int n);
    for (int i = 0; i < 100 && ndone == n; i++) @(posedge clk_sys);
    #1;
    if (ndone == n) fails++;
    if (ndone == n) stop_test();
  endtask : wait_done
  task automatic shot;
    int n;
    n = ndone;
    host.wr(WR_ONE_SHOT, 8'ha5, 1'b1);
    wait_done(n);
  endtask : shot
  ////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [7:0] d;
    logic ok;
    host.rd(d, ok);
    check(d, 8'h00);
    foreach (ra[i]) rdp(ra[i], re[i]);
  endtask : t_reset
  task automatic t_conv;
    int n;
    n = ndone;
    adc_local  = 8'h80;
    adc_remote = 8'h7f;
    host.wr(WR_ONE_SHOT, 8'h00, 1'b1);
    rdp(RD_ALARM_FLAGS, 8'h80);
    wait_done(n);
    rdp(RD_LOCAL_VALUE, 8'h80);
    rdp(RD_REMOTE_VALUE, 8'h7f);
  endtask : t_conv
  task automatic t_regs;
    host.wr(WR_CONTROL, 8'hff, 1'b1);
    rdp(RD_CONTROL, 8'hc0);
    for (int i = 0; i < 4; i++) host.wr(WR_LOCAL_UPPER + i, 8'h11 * (i + 1), 1'b1);
    for (int i = 0; i < 4; i++) rdp(RD_LOCAL_UPPER + i, 8'h11 * (i + 1));
    host.wr(WR_RATE, 8'h07, 1'b1);
    rdp(RD_RATE, 8'h07);
    host.wr(WR_LOCAL_UPPER, 8'h10, 1'b0);
    rdp(RD_LOCAL_UPPER, 8'h11);
    rdp(8'h10, 8'h00);
    rdp(8'h20, 8'h00);
    host.wr(WR_CONTROL, 8'h40, 1'b1);
    host.wr(WR_LOCAL_UPPER, 8'h10, 1'b1);
    host.wr(WR_LOCAL_LOWER, 8'h80, 1'b1);
    host.wr(WR_REMOTE_UPPER, 8'h7f, 1'b1);
    host.wr(WR_REMOTE_LOWER, 8'h00, 1'b1);
  endtask : t_regs
  task automatic t_alarm;
    // limit writes above left local-under and remote-over flags standing
    rdp(RD_ALARM_FLAGS, 8'h30);
    rdp(RD_ALARM_FLAGS, 8'h00);
    adc_local  = 8'h11;
    adc_remote = 8'h00;
    shot();
    rdp(RD_ALARM_FLAGS, 8'h40);
    rdp(RD_ALARM_FLAGS, 8'h40);
    check({6'h00, alert_o, alert_oe}, 8'h01);
    adc_local = 8'h10;
    shot();
    rdp(RD_ALARM_FLAGS, 8'h40);
    rdp(RD_ALARM_FLAGS, 8'h00);
    check({7'h00, alert_oe}, 8'h01);
    @(posedge clk_sys) #1 alert_resp = 1'b1;
    @(posedge clk_sys) #1 alert_resp = 1'b0;
    check({7'h00, alert_oe}, 8'h00);
    host.wr(WR_CONTROL, 8'hc0, 1'b1);
    adc_remote = 8'hff;
    adc_open   = 1'b1;
    shot();
    rdp(RD_ALARM_FLAGS, 8'h0c);
    check({7'h00, alert_oe}, 8'h00);
    host.wr(WR_CONTROL, 8'h40, 1'b1);
    check({7'h00, alert_oe}, 8'h01);
  endtask : t_alarm
  task automatic t_standby;
    int n;
    n = nstart;
    repeat (600) @(posedge clk_sys);
    #1;
    check(8'(nstart - n), 8'h00);
    shot();
    check(8'(nstart - n), 8'h01);
    host.wr(WR_CONTROL, 8'h00, 1'b1);
    standby_pin_n = 1'b0;
    repeat (300) @(posedge clk_sys);
    #1;
    check(8'(nstart - n), 8'h01);
    standby_pin_n = 1'b1;
    @(posedge clk_sys) #1 n = nstart;
    // look after the edge so the start counted on it is included
    repeat (64) @(posedge clk_sys);
    #1;
    check(8'(nstart - n), 8'h04);
  endtask : t_standby
  ////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    t_reset();
    t_conv();
    t_regs();
    t_alarm();
    t_standby();
    stop_test();
  end
endmodule : test_temp_monitor_register_bank
